// ===== hdl/adc_control_and_result_regs.sv
// control, sequencing and result registers of a 12-bit converter
// assumes the analog core delivers its result on conv_data_in at the last conversion tick
// What this block does
// (R01) every sample gives a 12-bit result, external or internal source
// (R02) source chosen by input source field together with external channel field
// (R03) internal source selected disconnects the external channel input
// (R04) justify 0: high byte bits 11..4, low byte bits 3..0 then zeros
// (R05) justify 1: high byte zeros then bits 11..8, low byte bits 7..0
// (R06) result bits not carrying data read as zero
// (R07) result pair unchanged while converter is disabled
// (R08) start bit written high then low begins a conversion
// (R09) start bit high holds conversion logic in reset
// (R10) busy set when start falls after being high
// (R11) busy clears when conversion completes, zero when idle
// (R12) busy bit is read-only, writes ignored
// (R13) enable bit must be set; clear powers the converter down
// (R14) channel code 00..11 routes channel 0..3
// (R15) bits 3 and 2 of first control register read zero
// (R16) analog-configured pin loses digital function and pull-high
// (R17) source codes: external, internal or reserved ground
// (R18) conversion clock divides system clock by 1 to 128
// (R19) result updates in the cycle busy clears
//
// Local design decisions: the register addresses and the strobed register port.
module adc_control_and_result_regs
    import adc_ctrl_pkg::*;
#(
    parameter logic [CONV_CNT_W-1:0] CONV_TICKS = CONV_TICKS_DEFAULT
)
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // register port
    input wire logic [2:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [7:0] reg_rdata_out,
    // interrupt
    output logic irq_out,
    // analog core
    input wire logic [RESULT_W-1:0] conv_data_in,
    output logic converter_power_out,
    output logic converter_reset_out,
    output logic conv_clk_tick_out,
    output logic conversion_busy_flag_out,
    // input routing
    output logic ext_channel_connect_out,
    output logic [1:0] external_channel_select_out,
    output logic internal_source_connect_out,
    output logic [2:0] internal_source_select_out,
    output logic ground_select_out,
    // reference and gain amplifier controls
    output logic gain_amp_enable_out,
    output logic gain_amp_input_select_out,
    output logic [1:0] reference_voltage_select_out,
    output logic [1:0] gain_amp_gain_select_out,
    // pin sharing
    input wire logic [CHANNELS-1:0] analog_input_pins_cfg_in,
    output logic [CHANNELS-1:0] pin_digital_off_out,
    output logic [CHANNELS-1:0] pin_pullup_off_out
);

    typedef struct packed {
        logic start;
        logic enable;
        logic justify;
        logic [1:0] ext_sel;
        logic [3:0] src_sel;
        logic [2:0] clk_sel;
        logic [7:0] ref_gain;
        logic [RESULT_W-1:0] result;
        logic busy;
        logic [DIV_W-1:0] div_cnt;
        logic tick;
        logic [CONV_CNT_W-1:0] conv_cnt;
        logic done_sts;
        logic done_mask;
        logic irq;
        logic [7:0] rd_data;
        logic ext_conn;
        logic [1:0] ext_mux;
        logic int_conn;
        logic [2:0] int_sel;
        logic gnd_sel;
        logic [CHANNELS-1:0] pin_off;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic src_external;
    logic src_reserved;
    logic [DIV_W-1:0] div_mask;
    logic wr_c0;
    logic start_fall;
    logic conv_last;

    // reserved codes 10xx go to ground, 0000, 0100 and 11xx are external
    always_comb
    begin
        src_reserved = (s_q.src_sel[3:2] == 2'h2); // R17
        src_external = ((s_q.src_sel[1:0] == 2'h0) && !s_q.src_sel[3])
                       || (s_q.src_sel[3:2] == 2'h3); // R17
    end

    assign div_mask = DIV_W'((8'h01 << s_q.clk_sel) - 8'h01); // R18
    assign wr_c0 = reg_write_in && (reg_addr_in == OFS_START_ENABLE_CHANNEL);
    assign start_fall = wr_c0 && s_q.start && !reg_wdata_in[BIT_START]; // R08
    assign conv_last = s_q.busy && s_q.tick && (s_q.conv_cnt == CONV_TICKS - 8'h01);

    always_comb
    begin
        s_d = s_q;
        s_d.rd_data = 8'h00;

        // register writes
        if (reg_write_in)
        begin
            case (reg_addr_in)
                OFS_START_ENABLE_CHANNEL:
                begin
                    // busy bit position is not writable
                    s_d.start = reg_wdata_in[BIT_START];
                    s_d.enable = reg_wdata_in[BIT_ENABLE];
                    s_d.justify = reg_wdata_in[BIT_JUSTIFY];
                    s_d.ext_sel = reg_wdata_in[POS_EXT_SEL +: 2];
                end
                OFS_SOURCE_CLOCK_SELECT:
                begin
                    s_d.src_sel = reg_wdata_in[POS_SRC_SEL +: 4];
                    s_d.clk_sel = reg_wdata_in[POS_CLK_SEL +: 3];
                end
                OFS_REFERENCE_GAIN_SELECT:
                begin
                    s_d.ref_gain = reg_wdata_in & REF_GAIN_WRITE_MASK;
                end
                OFS_IRQ_STATUS:
                begin
                    if (reg_wdata_in[BIT_IRQ_DONE])
                    begin
                        s_d.done_sts = 1'b0;
                    end
                end
                OFS_IRQ_MASK:
                begin
                    s_d.done_mask = reg_wdata_in[BIT_IRQ_DONE];
                end
                default:
                begin
                    s_d.done_mask = s_q.done_mask;
                end
            endcase
        end

        // conversion clock divider, held while stopped
        if (!s_q.enable || s_q.start || !s_q.busy || conv_last)
        begin
            s_d.div_cnt = '0;
            s_d.tick = 1'b0;
        end
        else
        begin
            s_d.div_cnt = s_q.div_cnt + DIV_W'(1);
            s_d.tick = ((s_q.div_cnt & div_mask) == '0); // R18
        end

        // conversion sequencing
        if (!s_q.enable)
        begin
            // powered down: abandon any conversion, keep the result pair
            s_d.busy = 1'b0; // R13 R07
            s_d.conv_cnt = '0;
        end
        else if (s_q.start)
        begin
            // a start fall that also clears the enable bit is ignored
            s_d.busy = start_fall && reg_wdata_in[BIT_ENABLE]; // R09 R10 R13
            s_d.conv_cnt = '0;
        end
        else if (conv_last)
        begin
            s_d.result = conv_data_in; // R01 R19
            s_d.busy = 1'b0; // R11
            s_d.conv_cnt = '0;
        end
        else if (s_q.busy && s_q.tick)
        begin
            s_d.conv_cnt = s_q.conv_cnt + CONV_CNT_W'(1);
        end

        // the completion event wins over a write-one clear in the same cycle
        if (s_q.enable && !s_q.start && conv_last)
        begin
            s_d.done_sts = 1'b1;
        end
        s_d.irq = s_d.done_sts && s_d.done_mask;

        // register reads, answer stands in the next cycle only
        if (reg_read_in)
        begin
            case (reg_addr_in)
                OFS_START_ENABLE_CHANNEL:
                    s_d.rd_data = {s_q.start, s_q.busy, s_q.enable, s_q.justify,
                                   2'h0, s_q.ext_sel}; // R12 R15
                OFS_SOURCE_CLOCK_SELECT:
                    s_d.rd_data = {s_q.src_sel, 1'b0, s_q.clk_sel};
                OFS_REFERENCE_GAIN_SELECT:
                    s_d.rd_data = s_q.ref_gain;
                OFS_RESULT_LOW_BYTE:
                    s_d.rd_data = s_q.justify ? s_q.result[7:0]
                                              : {s_q.result[3:0], 4'h0}; // R04 R05 R06
                OFS_RESULT_HIGH_BYTE:
                    s_d.rd_data = s_q.justify ? {4'h0, s_q.result[11:8]}
                                              : s_q.result[11:4]; // R04 R05 R06
                OFS_IRQ_STATUS:
                    s_d.rd_data = {7'h00, s_q.done_sts};
                OFS_IRQ_MASK:
                    s_d.rd_data = {7'h00, s_q.done_mask};
                default:
                    s_d.rd_data = 8'h00;
            endcase
        end

        // input routing; the external mux is opened for internal or ground sources
        s_d.ext_conn = s_q.enable && src_external; // R02 R03
        s_d.ext_mux = s_q.ext_sel; // R14
        s_d.int_conn = s_q.enable && !src_external && !src_reserved; // R02
        s_d.int_sel = s_q.src_sel[2:0];
        s_d.gnd_sel = src_reserved; // R17
        s_d.pin_off = analog_input_pins_cfg_in; // R16
    end

    // each pin set as analog drops its digital path and pull-high
    generate
        for (genvar i = 0; i < CHANNELS; i++)
        begin : g_pin
            assign pin_digital_off_out[i] = s_q.pin_off[i]; // R16
            assign pin_pullup_off_out[i] = s_q.pin_off[i]; // R16
        end
    endgenerate

    always_ff @(posedge ref_clk_in)
    begin
        if (!reset_n_in)
        begin
            s_q <= '0;
            s_q.start <= RST_START_ENABLE_CHANNEL[BIT_START];
            s_q.src_sel <= RST_SOURCE_CLOCK_SELECT[POS_SRC_SEL +: 4];
            s_q.ref_gain <= RST_REFERENCE_GAIN_SELECT;
            s_q.result <= RST_RESULT;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign reg_rdata_out = s_q.rd_data;
    assign irq_out = s_q.irq;
    assign converter_power_out = s_q.enable; // R13
    assign converter_reset_out = s_q.start; // R09
    assign conv_clk_tick_out = s_q.tick;
    assign conversion_busy_flag_out = s_q.busy;
    assign ext_channel_connect_out = s_q.ext_conn;
    assign external_channel_select_out = s_q.ext_mux;
    assign internal_source_connect_out = s_q.int_conn;
    assign internal_source_select_out = s_q.int_sel;
    assign ground_select_out = s_q.gnd_sel;
    assign gain_amp_enable_out = s_q.ref_gain[7];
    assign gain_amp_input_select_out = s_q.ref_gain[4];
    assign reference_voltage_select_out = s_q.ref_gain[3:2];
    assign gain_amp_gain_select_out = s_q.ref_gain[1:0];

    // checks
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    property p_busy_set;
        start_fall && s_q.enable && reg_wdata_in[BIT_ENABLE]
            |=> s_q.busy ##1 (s_q.busy || $past(conv_last));
    endproperty
    a_busy_set: assert property (p_busy_set) else $error("busy not set on start fall"); // R10

    property p_start_reset;
        s_q.start |=> !s_q.tick && s_q.conv_cnt == '0;
    endproperty
    a_start_reset: assert property (p_start_reset) else $error("start high not resetting"); // R09

    property p_busy_ro;
        wr_c0 && !start_fall && !conv_last && s_q.enable && !s_q.start
            && reg_wdata_in[BIT_START] == 1'b0 |=> $stable(s_q.busy);
    endproperty
    a_busy_ro: assert property (p_busy_ro) else $error("busy changed by write"); // R12

    property p_hold_disabled;
        !s_q.enable |=> $stable(s_q.result);
    endproperty
    a_hold_disabled: assert property (p_hold_disabled) else $error("result moved while off"); // R07

    property p_done_update;
        conv_last && s_q.enable && !s_q.start
            |=> !s_q.busy && s_q.result == $past(conv_data_in) && s_q.done_sts;
    endproperty
    a_done_update: assert property (p_done_update) else $error("result not taken at done"); // R19

    property p_fmt_left;
        reg_read_in && reg_addr_in == OFS_RESULT_LOW_BYTE && !s_q.justify
            |=> reg_rdata_out == {$past(s_q.result[3:0]), 4'h0};
    endproperty
    a_fmt_left: assert property (p_fmt_left) else $error("left low byte wrong"); // R04

    property p_fmt_right;
        reg_read_in && reg_addr_in == OFS_RESULT_HIGH_BYTE && s_q.justify
            |=> reg_rdata_out == {4'h0, $past(s_q.result[11:8])};
    endproperty
    a_fmt_right: assert property (p_fmt_right) else $error("right high byte wrong"); // R05

    property p_c0_reserved;
        reg_read_in && reg_addr_in == OFS_START_ENABLE_CHANNEL |=> reg_rdata_out[3:2] == 2'h0;
    endproperty
    a_c0_reserved: assert property (p_c0_reserved) else $error("reserved bits not zero"); // R15

    property p_ext_off;
        s_q.enable && !src_external |=> !ext_channel_connect_out;
    endproperty
    a_ext_off: assert property (p_ext_off) else $error("external input left on"); // R03

    property p_fmt_right_low;
        reg_read_in && reg_addr_in == OFS_RESULT_LOW_BYTE && s_q.justify
            |=> reg_rdata_out == $past(s_q.result[7:0]);
    endproperty
    a_fmt_right_low: assert property (p_fmt_right_low) else $error("right low byte wrong"); // R05

    property p_fmt_left_high;
        reg_read_in && reg_addr_in == OFS_RESULT_HIGH_BYTE && !s_q.justify
            |=> reg_rdata_out == $past(s_q.result[11:4]);
    endproperty
    a_fmt_left_high: assert property (p_fmt_left_high) else $error("left high byte wrong"); // R04

    property p_ext_route;
        s_q.enable && src_external
            |=> ext_channel_connect_out && external_channel_select_out == $past(s_q.ext_sel);
    endproperty
    a_ext_route: assert property (p_ext_route) else $error("external channel not routed"); // R14

    property p_int_route;
        s_q.enable && !src_external && !src_reserved
            |=> internal_source_connect_out
                && internal_source_select_out == $past(s_q.src_sel[2:0]);
    endproperty
    a_int_route: assert property (p_int_route) else $error("internal source not routed"); // R02

    property p_gnd_route;
        src_reserved
            |=> ground_select_out && !internal_source_connect_out && !ext_channel_connect_out;
    endproperty
    a_gnd_route: assert property (p_gnd_route) else $error("reserved source not grounded"); // R17

    property p_tick_busy;
        conv_clk_tick_out |-> conversion_busy_flag_out;
    endproperty
    a_tick_busy: assert property (p_tick_busy) else $error("tick outside a conversion"); // R18

    property p_idle_busy;
        !s_q.busy && !start_fall |=> !s_q.busy;
    endproperty
    a_idle_busy: assert property (p_idle_busy) else $error("busy rose without start"); // R11

    property p_pin_off;
        1'b1
            |=> pin_digital_off_out == $past(analog_input_pins_cfg_in)
                && pin_pullup_off_out == $past(analog_input_pins_cfg_in);
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("pin sharing not following config"); // R16

    c_conv_done: cover property (s_q.busy ##[1:600] !s_q.busy && s_q.done_sts);
    c_irq: cover property ($rose(irq_out));
    c_restart: cover property (s_q.busy && wr_c0 && reg_wdata_in[BIT_START]);
    c_right_low: cover property (reg_read_in && reg_addr_in == OFS_RESULT_LOW_BYTE && s_q.justify);

endmodule : adc_control_and_result_regs

// ===== include/adc_ctrl_pkg.sv
// constants for the converter control and result register block
// assumes an 8-bit register port and a successive-approximation core on the same clock
package adc_ctrl_pkg;
    // register offsets on the register port
    localparam logic [2:0] OFS_START_ENABLE_CHANNEL = 3'h0;
    localparam logic [2:0] OFS_SOURCE_CLOCK_SELECT = 3'h1;
    localparam logic [2:0] OFS_REFERENCE_GAIN_SELECT = 3'h2;
    localparam logic [2:0] OFS_RESULT_LOW_BYTE = 3'h3;
    localparam logic [2:0] OFS_RESULT_HIGH_BYTE = 3'h4;
    localparam logic [2:0] OFS_IRQ_STATUS = 3'h5;
    localparam logic [2:0] OFS_IRQ_MASK = 3'h6;
    // adc_start_enable_channel fields
    localparam int BIT_START = 7;
    localparam int BIT_BUSY = 6;
    localparam int BIT_ENABLE = 5;
    localparam int BIT_JUSTIFY = 4;
    localparam int POS_EXT_SEL = 0;
    // adc_source_clock_select fields
    localparam int POS_SRC_SEL = 4;
    localparam int POS_CLK_SEL = 0;
    // writable bits of adc_reference_gain_select
    localparam logic [7:0] REF_GAIN_WRITE_MASK = 8'h9f;
    // interrupt status and mask layout
    localparam int BIT_IRQ_DONE = 0;
    // reset values
    localparam logic [7:0] RST_START_ENABLE_CHANNEL = 8'h00;
    localparam logic [7:0] RST_SOURCE_CLOCK_SELECT = 8'h00;
    localparam logic [7:0] RST_REFERENCE_GAIN_SELECT = 8'h00;
    localparam logic [11:0] RST_RESULT = 12'h000;
    // widths and counts
    localparam int RESULT_W = 12;
    localparam int CHANNELS = 4;
    localparam int DIV_W = 7;
    localparam int CONV_CNT_W = 8;
    localparam logic [CONV_CNT_W-1:0] CONV_TICKS_DEFAULT = 8'h10;
endpackage : adc_ctrl_pkg

// ===== tb/adc_control_and_result_regs_tb.sv
// self-checking bench for the converter control and result registers
// assumes the sensor model drives the conversion data input
module adc_control_and_result_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import adc_ctrl_pkg::*;
    logic ref_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [2:0] reg_addr_in = 3'h0;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_write_in = 1'b0;
    logic reg_read_in = 1'b0;
    logic [3:0] pin_cfg = 4'h0;
    logic [11:0] level = 12'h000;
    logic [7:0] reg_rdata_out;
    logic irq_out, power, conv_reset, tick, busy, ext_con, int_con, gnd;
    logic [1:0] ext_sel;
    logic ga_en, ga_is;
    logic [1:0] vref_sel, gain_sel;
    logic [2:0] route_exp;
    logic [2:0] int_sel;
    logic [11:0] sample;
    logic [3:0] dig_off, pull_off;
    int err_count = 0;
    int samples_checked = 0;
    int seed = 32'h9601;
    int gap;
    logic [7:0] rd_v, lo_v;
    logic [3:0] code;
    logic [1:0] ch;
    logic just;

    always #10 ref_clk_in = ~ref_clk_in;

    adc_control_and_result_regs #(.CONV_TICKS(8'h02)) i_dut (.ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
        .irq_out(irq_out), .conv_data_in(sample), .converter_power_out(power),
        .converter_reset_out(conv_reset), .conv_clk_tick_out(tick),
        .conversion_busy_flag_out(busy), .ext_channel_connect_out(ext_con),
        .external_channel_select_out(ext_sel), .internal_source_connect_out(int_con),
        .internal_source_select_out(int_sel), .ground_select_out(gnd),
        .gain_amp_enable_out(ga_en), .gain_amp_input_select_out(ga_is),
        .reference_voltage_select_out(vref_sel),
        .gain_amp_gain_select_out(gain_sel), .analog_input_pins_cfg_in(pin_cfg),
        .pin_digital_off_out(dig_off), .pin_pullup_off_out(pull_off));

    sensor_model i_sensor (.ref_clk_in(ref_clk_in), .level_in(level), .ext_connect_in(ext_con),
        .ext_sel_in(ext_sel), .int_connect_in(int_con), .int_sel_in(int_sel), .gnd_in(gnd),
        .sample_out(sample));

    task automatic stop_test();
        if (err_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // every transfer ends one step past its edge so the registered outputs have settled
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        reg_write_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge ref_clk_in);
        reg_write_in <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge ref_clk_in);
        reg_read_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge ref_clk_in);
        reg_read_in <= 1'b0;
        #1;
        d = reg_rdata_out;
    endtask : rd

    function automatic logic [11:0] exp_res(input logic [3:0] c, input logic [1:0] n,
        input logic [11:0] l);
        if (c[3:2] == 2'b10)
            return 12'h000;
        if (!c[3] && c[1:0] != 2'b00)
            return {l[11:3], c[2:0]};
        return l ^ {10'h000, n};
    endfunction : exp_res

    function automatic logic [15:0] fmt(input logic [11:0] r, input logic j);
        return j ? {4'h0, r} : {r, 4'h0};
    endfunction : fmt

    // start high then low, then wait for completion while timing the tick spacing
    task automatic conv(input logic [7:0] c0);
        int t0;
        int n;
        t0 = -1;
        gap = -1;
        wr(OFS_START_ENABLE_CHANNEL, c0 | 8'h80);
        chk({15'h0, conv_reset}, 16'h0001);
        wr(OFS_START_ENABLE_CHANNEL, c0);
        chk({15'h0, busy}, {15'h0, c0[5]});
        for (n = 0; n < 600 && busy === 1'b1; n++)
        begin
            if (tick === 1'b1 && t0 >= 0 && gap < 0)
                gap = n - t0;
            if (tick === 1'b1 && t0 < 0)
                t0 = n;
            @(posedge ref_clk_in);
            #1;
        end
        chk({15'h0, busy}, 16'h0000);
    endtask : conv

    initial
    begin
        #(20 * 60000);
        err_count++;
        stop_test();
    end

    initial
    begin
        repeat (2) @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
        for (int a = 0; a < 3; a++)
        begin
            rd(a[2:0], rd_v);
            chk({8'h0, rd_v}, 16'h0000);
        end
        rd(3'h7, rd_v);
        chk({8'h0, rd_v}, 16'h0000);
        wr(OFS_START_ENABLE_CHANNEL, 8'h5f);
        rd(OFS_START_ENABLE_CHANNEL, rd_v);
        chk({8'h0, rd_v}, 16'h0013);
        wr(OFS_REFERENCE_GAIN_SELECT, 8'hff);
        chk({10'h0, ga_en, ga_is, vref_sel, gain_sel}, 16'h003f);
        rd(OFS_REFERENCE_GAIN_SELECT, rd_v);
        chk({8'h0, rd_v}, {8'h0, REF_GAIN_WRITE_MASK});
        wr(OFS_REFERENCE_GAIN_SELECT, 8'h52);
        chk({10'h0, ga_en, ga_is, vref_sel, gain_sel}, 16'h0012);
        wr(OFS_SOURCE_CLOCK_SELECT, 8'hff);
        rd(OFS_SOURCE_CLOCK_SELECT, rd_v);
        chk({8'h0, rd_v}, 16'h00f7);
        for (int c = 0; c < 16; c++)
        begin
            code = c[3:0];
            wr(OFS_SOURCE_CLOCK_SELECT, {code, 4'h0});
            wr(OFS_START_ENABLE_CHANNEL, 8'h20 | {6'h0, code[1:0]});
            // routing outputs follow the control fields one cycle later
            @(posedge ref_clk_in);
            #1;
            route_exp = {(!code[3] && code[1:0] == 2'b00) || code[3:2] == 2'b11,
                !code[3] && code[1:0] != 2'b00, code[3:2] == 2'b10};
            chk({13'h0, ext_con, int_con, gnd}, {13'h0, route_exp});
            chk({14'h0, ext_sel}, {14'h0, code[1:0]});
        end
        wr(OFS_IRQ_MASK, 8'h01);
        for (int k = 0; k < 14; k++)
        begin
            code = $random(seed);
            ch = $random(seed);
            just = $random(seed);
            level = $random(seed);
            pin_cfg <= $random(seed);
            wr(OFS_SOURCE_CLOCK_SELECT, {code, 4'h0});
            conv({2'b00, 1'b1, just, 2'b00, ch});
            chk({15'h0, irq_out}, 16'h0001);
            rd(OFS_RESULT_LOW_BYTE, lo_v);
            rd(OFS_RESULT_HIGH_BYTE, rd_v);
            chk({rd_v, lo_v}, fmt(exp_res(code, ch, level), just));
            wr(OFS_IRQ_STATUS, 8'h01);
            chk({15'h0, irq_out}, 16'h0000);
            chk({8'h0, dig_off, pull_off}, {8'h0, pin_cfg, pin_cfg});
        end
        for (int j = 0; j < 2; j++)
        begin
            level = 12'h9c5;
            wr(OFS_SOURCE_CLOCK_SELECT, 8'h00);
            conv({3'b001, j[0], 4'h2});
            chk({15'h0, power}, 16'h0001);
            wr(OFS_START_ENABLE_CHANNEL, {3'b000, j[0], 4'h2});
            chk({15'h0, power}, 16'h0000);
            level = 12'h36a;
            conv({3'b000, j[0], 4'h2});
            rd(OFS_RESULT_LOW_BYTE, lo_v);
            rd(OFS_RESULT_HIGH_BYTE, rd_v);
            chk({rd_v, lo_v}, fmt(12'h9c5 ^ 12'h002, j[0]));
        end
        wr(OFS_IRQ_MASK, 8'h00);
        for (int d = 0; d < 8; d++)
        begin
            wr(OFS_SOURCE_CLOCK_SELECT, d[7:0]);
            conv(8'h20);
            chk(gap[15:0], 16'h0001 << d);
        end
        chk({15'h0, irq_out}, 16'h0000);
        rd(OFS_IRQ_STATUS, rd_v);
        chk({15'h0, rd_v[0]}, 16'h0001);
        stop_test();
    end
endmodule : adc_control_and_result_regs_tb

// ===== tb/sensor_model.sv
// sensor signals standing in front of the converter input mux
// assumes the routing outputs of the control block and one system clock
module sensor_model
(
    // clock
    input wire logic ref_clk_in,
    // sensor level and routing from the block
    input wire logic [11:0] level_in,
    input wire logic ext_connect_in,
    input wire logic [1:0] ext_sel_in,
    input wire logic int_connect_in,
    input wire logic [2:0] int_sel_in,
    input wire logic gnd_in,
    // value seen by the analog core
    output logic [11:0] sample_out
);
    logic [11:0] drift_q = 12'h5a3;

    // an open input floats, so it wanders every cycle instead of holding a value
    always_ff @(posedge ref_clk_in)
        drift_q <= drift_q + 12'h3b7;

    always_comb
    begin
        if (gnd_in)
            sample_out = 12'h000;
        else if (int_connect_in)
            sample_out = {level_in[11:3], int_sel_in};
        else if (ext_connect_in)
            sample_out = level_in ^ {10'h000, ext_sel_in};
        else
            sample_out = drift_q;
    end
endmodule : sensor_model
